/* File: rtl/spl_pkg.sv */
// Purpose: Constants for the preload word loader of port configuration bits
// Assumes: 16-bit preload words, byte-style word addresses
// Notes:   Field positions are word bit positions
package spl_pkg;
  localparam int unsigned SPL_WORD_W        = 16;
  localparam int unsigned SPL_ADDR_W        = 8;
  localparam int unsigned SPL_NPORT         = 4;
  // Word addresses
  localparam logic [7:0]  SPL_ADDR_PHY_P0   = 8'h40;
  localparam logic [7:0]  SPL_ADDR_PHY_P1   = 8'h42;
  localparam logic [7:0]  SPL_ADDR_PHY_P2   = 8'h44;
  localparam logic [7:0]  SPL_ADDR_PHY_P3   = 8'h46;
  localparam logic [7:0]  SPL_ADDR_PM_P0    = 8'h50;
  localparam logic [7:0]  SPL_ADDR_PMD_P0   = 8'h51;
  localparam logic [7:0]  SPL_ADDR_PM_P1    = 8'h52;
  localparam logic [7:0]  SPL_ADDR_PMD_P1   = 8'h53;
  localparam logic [7:0]  SPL_ADDR_LAST     = 8'h53;
  // Word field positions, phy word
  localparam int unsigned SPL_F_TUNB_LO     = 0;
  localparam int unsigned SPL_F_TUNB_W      = 5;
  localparam int unsigned SPL_F_TUNC_LO     = 5;
  localparam int unsigned SPL_F_TUNC_W      = 7;
  localparam int unsigned SPL_F_DEEMPH      = 12;
  localparam int unsigned SPL_F_COMPL       = 13;
  localparam int unsigned SPL_F_DCNT_LO     = 14;
  localparam int unsigned SPL_F_DCNT_W      = 2;
  // Word field positions, power word
  localparam int unsigned SPL_F_NSR         = 0;
  localparam int unsigned SPL_F_AUX_LO      = 1;
  localparam int unsigned SPL_F_AUX_W       = 3;
  localparam int unsigned SPL_F_PME_LO      = 6;
  localparam int unsigned SPL_F_PME_W       = 2;
  localparam int unsigned SPL_F_PMD_LO      = 8;
  localparam int unsigned SPL_F_PMD_W       = 8;
  // Reset values
  localparam logic [4:0]  SPL_RST_TUNB      = 5'h00;
  localparam logic [6:0]  SPL_RST_TUNC      = 7'h00;
  localparam logic [1:0]  SPL_RST_DCNT      = 2'h0;
  localparam logic [2:0]  SPL_RST_AUX       = 3'h0;
  localparam logic [1:0]  SPL_RST_PME       = 2'h0;
  localparam logic [7:0]  SPL_RST_PMD       = 8'h00;
  // D1 and D2 support read back as set
  localparam logic        SPL_D1_SUPPORT    = 1'b1;
  localparam logic        SPL_D2_SUPPORT    = 1'b1;

  typedef enum logic [1:0] {
    SPL_IDLE,
    SPL_REQ,
    SPL_WAIT,
    SPL_DONE
  } spl_state_e;
endpackage : spl_pkg

/* File: rtl/spl_word_decode.sv */
// Purpose: Splits one preload word into port fields
// Assumes: Pure combinational decode
// Notes:   Used by the loader for both word kinds
`timescale 1ns/1ps
`default_nettype none
module spl_word_decode
  import spl_pkg::*;
(
  // Word in
  input  wire logic [15:0] i_word,
  // Phy fields
  output logic      [4:0]  o_tunb,
  output logic      [6:0]  o_tunc,
  output logic             o_deemph,
  output logic             o_compl,
  output logic      [1:0]  o_dcnt,
  // Power fields
  output logic             o_nsr,
  output logic      [2:0]  o_aux,
  output logic      [1:0]  o_pme,
  output logic      [7:0]  o_pmd
);
  always_comb begin
    o_tunb   = i_word[SPL_F_TUNB_LO +: SPL_F_TUNB_W];
    o_tunc   = i_word[SPL_F_TUNC_LO +: SPL_F_TUNC_W];
    o_deemph = i_word[SPL_F_DEEMPH];
    o_compl  = i_word[SPL_F_COMPL];
    o_dcnt   = i_word[SPL_F_DCNT_LO +: SPL_F_DCNT_W];
    o_nsr    = i_word[SPL_F_NSR];
    o_aux    = i_word[SPL_F_AUX_LO +: SPL_F_AUX_W];
    o_pme    = i_word[SPL_F_PME_LO +: SPL_F_PME_W];
    o_pmd    = i_word[SPL_F_PMD_LO +: SPL_F_PMD_W];
  end
endmodule : spl_word_decode
`default_nettype wire

/* File: rtl/spl_loader.sv */
// Purpose: Copies preload words 40h-46h and 50h-53h into port config bits
// Assumes: Memory answers each request with a valid pulse, any latency
// Notes:   Config access is held off until o_load_done is high
//
// What this block does
// - Word 42h bits 4:0 go to port 1 offset 7Ch bits 12:8.
// - Word 42h bits 11:5 go to port 1 offset 90h bits 6:0.
// - Word 42h bit 12 goes to port 1 de-emphasis, F0h bit 6.
// - Word 42h bit 13 goes to port 1 compliance-to-detect, 78h bit 11.
// - Word 42h bits 15:14 go to port 1 data-count select, 8Ch bits 9:8.
// - Word 44h uses the same layout for port 2.
// - Word 46h uses the same layout for port 3.
// - Port 0 word bits 15:14 go to port 0 data-count select.
// - Word 40h loads port 0 tuning, de-emphasis and compliance fields.
// - Word 50h bit 0 goes to port 0 no-soft-reset, 44h bit 3.
// - Word 50h bits 3:1 go to port 0 aux current, 40h bits 24:22.
// - D1 and D2 support bits read back as one.
// - Capability word bits 7:6 go to event support, 40h bits 29:28.
// - Word 51h bits 15:8 go to port 0 power data, 44h bits 31:24.
// - Word 52h carries port 1 no-soft-reset, aux current and event support.
// - Word 53h bits 15:8 go to port 1 power data.
`timescale 1ns/1ps
`default_nettype none
module spl_loader
  import spl_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  // Control
  input  wire logic        i_start,
  // Memory read port
  output logic             o_mem_req,
  output logic [7:0]       o_mem_addr,
  input  wire logic        i_mem_valid,
  input  wire logic [15:0] i_mem_data,
  // Status
  output logic             o_busy,
  output logic             o_load_done,
  output logic             o_cfg_access_en,
  // Phy fields, one slice per port
  output logic [19:0]      o_phy_tuning_field_b,
  output logic [27:0]      o_phy_tuning_field_c,
  output logic [3:0]       o_deemph_sel,
  output logic [3:0]       o_compliance_to_detect,
  output logic [7:0]       o_change_data_count_select,
  // Power fields, ports 0 and 1
  output logic [1:0]       o_no_soft_reset,
  output logic [5:0]       o_aux_current,
  output logic [1:0]       o_d1_support,
  output logic [1:0]       o_d2_support,
  output logic [3:0]       o_pme_support,
  output logic [15:0]      o_pm_data
);
  spl_state_e  state_r,  state_nxt;
  logic [7:0]  addr_r,   addr_nxt;
  logic        done_r,   done_nxt;
  logic [4:0]  tunb_r    [SPL_NPORT];
  logic [4:0]  tunb_nxt  [SPL_NPORT];
  logic [6:0]  tunc_r    [SPL_NPORT];
  logic [6:0]  tunc_nxt  [SPL_NPORT];
  logic [3:0]  deemph_r, deemph_nxt;
  logic [3:0]  compl_r,  compl_nxt;
  logic [1:0]  dcnt_r    [SPL_NPORT];
  logic [1:0]  dcnt_nxt  [SPL_NPORT];
  logic [1:0]  nsr_r,    nsr_nxt;
  logic [2:0]  aux_r     [2];
  logic [2:0]  aux_nxt   [2];
  logic [1:0]  pme_r     [2];
  logic [1:0]  pme_nxt   [2];
  logic [7:0]  pmd_r     [2];
  logic [7:0]  pmd_nxt   [2];

  logic [4:0]  w_tunb;
  logic [6:0]  w_tunc;
  logic        w_deemph;
  logic        w_compl;
  logic [1:0]  w_dcnt;
  logic        w_nsr;
  logic [2:0]  w_aux;
  logic [1:0]  w_pme;
  logic [7:0]  w_pmd;

  spl_word_decode u_dec (
    .i_word   (i_mem_data),
    .o_tunb   (w_tunb),
    .o_tunc   (w_tunc),
    .o_deemph (w_deemph),
    .o_compl  (w_compl),
    .o_dcnt   (w_dcnt),
    .o_nsr    (w_nsr),
    .o_aux    (w_aux),
    .o_pme    (w_pme),
    .o_pmd    (w_pmd)
  );

  // Next word address; gap between 46h and 50h is skipped
  function automatic logic [7:0] next_addr(input logic [7:0] a);
    if (a == SPL_ADDR_PHY_P3) begin
      next_addr = SPL_ADDR_PM_P0;
    end else if (a < SPL_ADDR_PHY_P3) begin
      next_addr = 8'(a + 8'h02);
    end else begin
      next_addr = 8'(a + 8'h01);
    end
  endfunction : next_addr

  always_comb begin
    state_nxt  = state_r;
    addr_nxt   = addr_r;
    done_nxt   = done_r;
    tunb_nxt   = tunb_r;
    tunc_nxt   = tunc_r;
    deemph_nxt = deemph_r;
    compl_nxt  = compl_r;
    dcnt_nxt   = dcnt_r;
    nsr_nxt    = nsr_r;
    aux_nxt    = aux_r;
    pme_nxt    = pme_r;
    pmd_nxt    = pmd_r;
    case (state_r)
      SPL_IDLE: begin
        if (i_start) begin
          addr_nxt  = SPL_ADDR_PHY_P0;
          done_nxt  = 1'b0;
          state_nxt = SPL_REQ;
        end
      end
      SPL_REQ: begin
        state_nxt = SPL_WAIT;
      end
      SPL_WAIT: begin
        if (i_mem_valid) begin
          case (addr_r)
            SPL_ADDR_PHY_P0, SPL_ADDR_PHY_P1, SPL_ADDR_PHY_P2, SPL_ADDR_PHY_P3: begin
              // Port index from address bits 2:1
              tunb_nxt[addr_r[2:1]]   = w_tunb;
              tunc_nxt[addr_r[2:1]]   = w_tunc;
              deemph_nxt[addr_r[2:1]] = w_deemph;
              compl_nxt[addr_r[2:1]]  = w_compl;
              dcnt_nxt[addr_r[2:1]]   = w_dcnt;
            end
            SPL_ADDR_PM_P0, SPL_ADDR_PM_P1: begin
              nsr_nxt[addr_r[1]] = w_nsr;
              aux_nxt[addr_r[1]] = w_aux;
              pme_nxt[addr_r[1]] = w_pme;
            end
            SPL_ADDR_PMD_P0, SPL_ADDR_PMD_P1: begin
              pmd_nxt[addr_r[1]] = w_pmd;
            end
            default: begin
            end
          endcase
          if (addr_r == SPL_ADDR_LAST) begin
            state_nxt = SPL_DONE;
          end else begin
            addr_nxt  = next_addr(addr_r);
            state_nxt = SPL_REQ;
          end
        end
      end
      SPL_DONE: begin
        done_nxt  = 1'b1;
        state_nxt = SPL_IDLE;
      end
      default: begin
        state_nxt = SPL_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r  <= SPL_IDLE;
      addr_r   <= SPL_ADDR_PHY_P0;
      done_r   <= 1'b0;
      deemph_r <= 4'h0;
      compl_r  <= 4'h0;
      nsr_r    <= 2'h0;
      for (int i = 0; i < SPL_NPORT; i++) begin
        tunb_r[i] <= SPL_RST_TUNB;
        tunc_r[i] <= SPL_RST_TUNC;
        dcnt_r[i] <= SPL_RST_DCNT;
      end
      for (int i = 0; i < 2; i++) begin
        aux_r[i] <= SPL_RST_AUX;
        pme_r[i] <= SPL_RST_PME;
        pmd_r[i] <= SPL_RST_PMD;
      end
    end else begin
      state_r  <= state_nxt;
      addr_r   <= addr_nxt;
      done_r   <= done_nxt;
      tunb_r   <= tunb_nxt;
      tunc_r   <= tunc_nxt;
      deemph_r <= deemph_nxt;
      compl_r  <= compl_nxt;
      dcnt_r   <= dcnt_nxt;
      nsr_r    <= nsr_nxt;
      aux_r    <= aux_nxt;
      pme_r    <= pme_nxt;
      pmd_r    <= pmd_nxt;
    end
  end

  // Request is a one-cycle pulse; address held until the answer
  assign o_mem_req       = (state_r == SPL_REQ);
  assign o_mem_addr      = addr_r;
  assign o_busy          = (state_r != SPL_IDLE);
  assign o_load_done     = done_r;
  // Host config access blocked while a load runs or before the first one ends
  assign o_cfg_access_en = done_r && (state_r == SPL_IDLE);

  always_comb begin
    for (int i = 0; i < SPL_NPORT; i++) begin
      o_phy_tuning_field_b[i*5 +: 5]     = tunb_r[i];
      o_phy_tuning_field_c[i*7 +: 7]     = tunc_r[i];
      o_change_data_count_select[i*2 +: 2] = dcnt_r[i];
    end
    for (int i = 0; i < 2; i++) begin
      o_aux_current[i*3 +: 3] = aux_r[i];
      o_pme_support[i*2 +: 2] = pme_r[i];
      o_pm_data[i*8 +: 8]     = pmd_r[i];
    end
  end
  assign o_deemph_sel           = deemph_r;
  assign o_compliance_to_detect = compl_r;
  assign o_no_soft_reset        = nsr_r;
  // Fixed support, not loaded
  assign o_d1_support = {2{SPL_D1_SUPPORT}};
  assign o_d2_support = {2{SPL_D2_SUPPORT}};
endmodule : spl_loader
`default_nettype wire

/* File: testbench/spl_mem_model.sv */
// Purpose: Preload memory model, one word per request
// Assumes: Word is address pattern, port bits and salt xored
// Notes:   Idle data bus toggles, never holds the last word
`timescale 1ns/1ps
`default_nettype none
module spl_mem_model (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  // Request side
  input  wire logic        i_req,
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_salt,
  input  wire logic [3:0]  i_lat,
  // Answer side
  output logic             o_valid,
  output logic      [15:0] o_data
);
  logic        pend_r;
  logic [3:0]  cnt_r;
  logic [7:0]  addr_r;
  logic [15:0] last_r;
  assign o_valid = pend_r && (cnt_r == 4'h0);
  // Port bits folded in, else high fields match on every port and a port swap hides
  assign o_data  = o_valid ? ({addr_r, addr_r} ^ {8{addr_r[2:1]}} ^ i_salt) : ~last_r;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_r <= 1'b0;
      cnt_r  <= 4'h0;
      addr_r <= 8'h00;
      last_r <= 16'h0000;
    end else begin
      last_r <= o_data;
      if (i_req) begin
        pend_r <= 1'b1;
        cnt_r  <= i_lat;
        addr_r <= i_addr;
      end else if (o_valid) pend_r <= 1'b0;
      else if (pend_r) cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : spl_mem_model
`default_nettype wire

/* File: testbench/spl_loader_props.sv */
// Purpose: Port checks of the preload word loader
// Assumes: Memory answers only while the loader waits
// Notes:   Snapshot of the last word taken drives the field checks
`timescale 1ns/1ps
`default_nettype none
module spl_loader_props (
  input wire logic        i_clk_sys, i_arst_n, o_mem_req, i_mem_valid, o_busy, o_load_done, o_cfg_access_en,
  input wire logic [7:0]  o_mem_addr, o_change_data_count_select,
  input wire logic [15:0] i_mem_data, o_pm_data,
  input wire logic [19:0] o_phy_tuning_field_b,
  input wire logic [27:0] o_phy_tuning_field_c,
  input wire logic [3:0]  o_deemph_sel, o_compliance_to_detect, o_pme_support,
  input wire logic [1:0]  o_no_soft_reset, o_d1_support, o_d2_support,
  input wire logic [5:0]  o_aux_current
);
  logic            tk_r;
  logic [7:0]      a_r;
  logic [15:0]     w_r;
  wire logic       take = i_mem_valid && o_busy && !o_mem_req;
  wire logic [1:0] p    = a_r[2:1];
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tk_r <= 1'b0;
      a_r  <= 8'h00;
      w_r  <= 16'h0000;
    end else begin
      tk_r <= take;
      a_r  <= o_mem_addr;
      w_r  <= i_mem_data;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  property p_tunb; tk_r && !a_r[4] |-> o_phy_tuning_field_b[5*p +: 5] == w_r[4:0]; endproperty
  a_tunb: assert property (p_tunb) else $error("tuning b");
  property p_tunc; tk_r && !a_r[4] |-> o_phy_tuning_field_c[7*p +: 7] == w_r[11:5]; endproperty
  a_tunc: assert property (p_tunc) else $error("tuning c");
  property p_dc; tk_r && !a_r[4] |-> o_deemph_sel[p] == w_r[12] && o_compliance_to_detect[p] == w_r[13]; endproperty
  a_dc: assert property (p_dc) else $error("deemph or compliance");
  property p_dcnt; tk_r && !a_r[4] |-> o_change_data_count_select[2*p +: 2] == w_r[15:14]; endproperty
  a_dcnt: assert property (p_dcnt) else $error("data count");
  property p_cap;
    tk_r && a_r[4] && !a_r[0] |-> o_no_soft_reset[p[0]] == w_r[0] && o_aux_current[3*p[0] +: 3] == w_r[3:1]
      && o_pme_support[2*p[0] +: 2] == w_r[7:6];
  endproperty
  a_cap: assert property (p_cap) else $error("power capability");
  property p_pmd; tk_r && a_r[4] && a_r[0] |-> o_pm_data[8*p[0] +: 8] == w_r[15:8]; endproperty
  a_pmd: assert property (p_pmd) else $error("power data");
  property p_dsup; o_d1_support == 2'b11 && o_d2_support == 2'b11; endproperty
  a_dsup: assert property (p_dsup) else $error("d1 d2 support");
  property p_end; take && o_mem_addr == 8'h53 |=> o_busy && !o_load_done ##1 !o_busy && o_cfg_access_en; endproperty
  a_end: assert property (p_end) else $error("late finish");
  // Access opens only straight after a load, then stays open until the next load starts
  property p_cfg;
    o_cfg_access_en |-> o_load_done && !o_busy && !o_mem_req && ($past(o_busy) || $past(o_cfg_access_en));
  endproperty
  a_cfg: assert property (p_cfg) else $error("early access");
  property p_first; $rose(o_busy) |-> o_mem_req && o_mem_addr == 8'h40; endproperty
  a_first: assert property (p_first) else $error("first word");
  c_load: cover property (o_busy ##1 o_cfg_access_en);
  c_restart: cover property (o_cfg_access_en ##1 o_busy);
  c_pmd: cover property (tk_r && a_r == 8'h53);
endmodule : spl_loader_props
bind spl_loader spl_loader_props u_props (.*);
`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: Self-checking bench of the preload word loader
// Assumes: Model word is address pattern, port bits and salt xored
// Notes:   Fast and slow memory, ignored start, reset mid-load
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        i_clk_sys, i_arst_n, i_start, o_mem_req, i_mem_valid, o_busy, o_load_done, o_cfg_access_en;
  logic [7:0]  o_mem_addr, o_change_data_count_select;
  logic [15:0] i_mem_data, o_pm_data, salt;
  logic [19:0] o_phy_tuning_field_b;
  logic [27:0] o_phy_tuning_field_c;
  logic [3:0]  o_deemph_sel, o_compliance_to_detect, o_pme_support, lat;
  logic [1:0]  o_no_soft_reset, o_d1_support, o_d2_support;
  logic [5:0]  o_aux_current;
  logic [7:0]  q[$];
  int          fails = 0, n_compared = 0, cyc = 0;
  spl_loader u_spl_loader (.*);
  spl_mem_model u_spl_mem_model (.i_clk_sys, .i_arst_n, .i_req(o_mem_req), .i_addr(o_mem_addr),
    .i_salt(salt), .i_lat(lat), .o_valid(i_mem_valid), .o_data(i_mem_data));
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  // Hang guard, far above three loads
  always @(posedge i_clk_sys) begin
    cyc++;
    if (o_mem_req === 1'b1) q.push_back(o_mem_addr);
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic cmp(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : cmp
  function automatic logic [15:0] word_of(input logic [7:0] a);
    word_of = {a, a} ^ {8{a[2:1]}} ^ salt;
  endfunction : word_of
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick
  task automatic t_reset_state();
    cmp({o_phy_tuning_field_b, o_phy_tuning_field_c, o_deemph_sel, o_compliance_to_detect} === '0, "rst phy");
    cmp({o_change_data_count_select, o_no_soft_reset, o_aux_current, o_pme_support, o_pm_data} === '0, "rst pwr");
    cmp({o_busy, o_load_done, o_cfg_access_en, o_mem_req, o_d1_support, o_d2_support, o_mem_addr} === 16'h0f40,
      "rst status");
  endtask : t_reset_state
  task automatic t_load(input logic [15:0] s, input logic [3:0] l, input bit poke);
    int n;
    logic [15:0] e, d;
    salt = s;
    lat = l;
    q.delete();
    i_start = 1'b1;
    tick(1);
    cmp(o_busy === 1'b1 && o_load_done === 1'b0 && o_cfg_access_en === 1'b0, "no hold-off");
    n = 0;
    // A start mid-load must not restart the sequence
    while (o_load_done !== 1'b1 && n < 300) begin
      i_start = poke && n == 4;
      tick(1);
      n++;
    end
    cmp(o_cfg_access_en === 1'b1 && o_busy === 1'b0 && q.size() == 8, "finish");
    for (int i = 0; i < 8; i++) cmp(q[i] === 8'(i < 4 ? 8'h40 + 2 * i : 8'h4c + i), "order");
    for (int i = 0; i < 4; i++) begin
      e = word_of(8'h40 + 8'(2 * i));
      cmp(o_phy_tuning_field_b[5*i +: 5] === e[4:0], "tune b");
      cmp(o_phy_tuning_field_c[7*i +: 7] === e[11:5], "tune c");
      cmp(o_deemph_sel[i] === e[12] && o_compliance_to_detect[i] === e[13], "dc");
      cmp(o_change_data_count_select[2*i +: 2] === e[15:14], "dcnt");
    end
    for (int i = 0; i < 2; i++) begin
      e = word_of(8'h50 + 8'(2 * i));
      d = word_of(8'h51 + 8'(2 * i));
      cmp(o_no_soft_reset[i] === e[0] && o_aux_current[3*i +: 3] === e[3:1], "cap");
      cmp(o_pme_support[2*i +: 2] === e[7:6] && o_pm_data[8*i +: 8] === d[15:8], "pm");
    end
  endtask : t_load
  task automatic t_reset_mid();
    salt = 16'h3c96;
    i_start = 1'b1;
    tick(6);
    i_arst_n = 1'b0;
    i_start = 1'b0;
    tick(1);
    t_reset_state();
    i_arst_n = 1'b1;
    tick(1);
  endtask : t_reset_mid
  task automatic end_of_test();
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    i_arst_n = 1'b0;
    i_start = 1'b0;
    salt = 16'h0000;
    lat = 4'h0;
    tick(5);
    t_reset_state();
    i_arst_n = 1'b1;
    tick(1);
    t_load(16'h5a3c, 4'h0, 1'b0);
    t_load(16'hffff, 4'h3, 1'b1);
    t_reset_mid();
    t_load(16'h0f0f, 4'h1, 1'b0);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
